// *** ccs_cfg.svh ***
// Constants for the core clock select and oscillator supervisor block
`ifndef CCS_CFG_SVH
`define CCS_CFG_SVH
`define CCS_STRAP_X4 3'h7
`define CCS_STRAP_X3 3'h6
`define CCS_STRAP_X2 3'h5
`define CCS_STRAP_X5 3'h4
`define CCS_STRAP_DIRECT 3'h3
`define CCS_STRAP_X1P5 3'h2
`define CCS_STRAP_PRESCALE 3'h1
`define CCS_STRAP_X2P5 3'h0
`define CCS_CFG_SUPV_DIS_BIT 4
`define CCS_WATCH_LIMIT 5'h10
`define CCS_FACTOR_RESET 4'h8
`endif

// *** ccs_clock_select.sv ***
// Core clock mode select and oscillator supervision
//***************************************************************
// Operation
//***************************************************************
// Operation
// R01 - The clock mode comes from three strap pins held by the outside during reset.
// R02 - Straps decode 111 x4, 110 x3, 101 x2, 100 x5, 011 x1, 010 x1.5, 001 x0.5, 000 x2.5.
// R03 - Strap 001 gives the core clock through a divide-by-two prescaler.
// R04 - Strap 011 turns the multiplier off and drives the core straight from the input clock.
// R05 - Every other strap enables the multiplier and uses its output as core clock.
// R06 - In multiplier mode the core is resynchronised to the input every factor-count of transitions.
// R07 - Supervision applies to direct drive with and without prescaler.
// R08 - Supervision is on after reset and bit 4 of the system config register turns it off.
// R09 - With supervision on the multiplier free-runs and a counter counts its cycles.
// R10 - Each input clock transition clears the supervision counter.
// R11 - A counter overflow after 16 free-running cycles means the input clock failed.
// R12 - On failure the core source switches to the free-running clock.
// R13 - On failure the clock-fail request flag is set together with the switch.
// R14 - The free-running source is kept until hardware reset even if the input returns.
// R15 - With supervision off the core uses the input clock and the multiplier is off.
// R16 - Input edges are synchronised before clearing, and failover is glitch-free.
// R17 - The decoded mode is latched at reset release and held until the next reset.
//***************************************************************
`timescale 1ns/1ps
`include "ccs_cfg.svh"
module ccs_clock_select (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [2:0] clock_mode_strap_pins_i,
	input wire logic crystal_input_pin_i,
	input wire logic [7:0] system_config_register_i,
	output ccs_pkg::ccs_sel_s sel_o,
	output logic multiplier_enable_o,
	output logic multiplier_freerun_o,
	output logic prescale_enable_o,
	output logic core_from_freerun_o,
	output logic resync_pulse_o,
	output logic clock_fail_irq_request_o
);
	//***************************************************************
	// Strap decode
	//***************************************************************
	function automatic ccs_pkg::ccs_sel_s decode_strap(input logic [2:0] s);
		ccs_pkg::ccs_sel_s r;
		r.mode = ccs_pkg::CCS_MODE_MULT; // R05
		case (s)
			`CCS_STRAP_X4: r.half_factor = 4'h8; // R02
			`CCS_STRAP_X3: r.half_factor = 4'h6;
			`CCS_STRAP_X2: r.half_factor = 4'h4;
			`CCS_STRAP_X5: r.half_factor = 4'ha;
			`CCS_STRAP_DIRECT: begin
				r.half_factor = 4'h2;
				r.mode = ccs_pkg::CCS_MODE_DIRECT; // R04
			end
			`CCS_STRAP_X1P5: r.half_factor = 4'h3;
			`CCS_STRAP_PRESCALE: begin
				r.half_factor = 4'h1;
				r.mode = ccs_pkg::CCS_MODE_PRESCALE; // R03
			end
			default: r.half_factor = 4'h5;
		endcase
		return r;
	endfunction : decode_strap

	// Mode latch: tracks the straps while in reset, freezes at release
	ccs_pkg::ccs_sel_s sel_reg, sel_next;
	always_comb begin
		sel_next = sel_reg;
		if (!rst_n_i) begin
			sel_next = decode_strap(clock_mode_strap_pins_i); // R01
		end
	end
	// No reset value; strap capture during reset runs through the next path
	always_ff @(posedge clock_i) begin
		sel_reg <= sel_next; // R17
	end

	//***************************************************************
	// Supervision
	//***************************************************************
	logic supv_on;
	logic direct_like;
	logic xtal_edge;
	logic overflow;
	logic failed_reg, failed_next;
	logic irq_reg, irq_next;
	logic [3:0] edge_cnt_reg, edge_cnt_next;
	logic resync_reg, resync_next;

	// Disable bit clear at reset by the register owner
	assign supv_on = !system_config_register_i[`CCS_CFG_SUPV_DIS_BIT]; // R08
	assign direct_like = (sel_reg.mode != ccs_pkg::CCS_MODE_MULT); // R07

	ccs_edge_sync u_edge_sync (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.level_i(crystal_input_pin_i),
		.edge_o(xtal_edge)
	); // R16

	ccs_watch_counter u_watch (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.run_i(supv_on && direct_like && !failed_reg),
		.clear_i(xtal_edge),
		.overflow_o(overflow)
	);

	// Failure is sticky; only reset clears source and request
	always_comb begin
		failed_next = failed_reg;
		irq_next = irq_reg;
		if (overflow && supv_on && direct_like) begin
			failed_next = 1'b1; // R12
			irq_next = 1'b1; // R13
		end
	end

	// Counts input transitions to mark each resync point of the multiplier
	always_comb begin
		edge_cnt_next = edge_cnt_reg;
		resync_next = 1'b0;
		if (sel_reg.mode == ccs_pkg::CCS_MODE_MULT && xtal_edge) begin
			// Transitions per resync equal the factor rounded up, i.e. one per two half steps
			if (edge_cnt_reg + 4'h1 >= (sel_reg.half_factor >> 1) + sel_reg.half_factor[0]) begin
				edge_cnt_next = 4'h0;
				resync_next = 1'b1; // R06
			end else begin
				edge_cnt_next = edge_cnt_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			failed_reg <= 1'b0; // R14
			irq_reg <= 1'b0;
			edge_cnt_reg <= 4'h0;
			resync_reg <= 1'b0;
		end else begin
			failed_reg <= failed_next;
			irq_reg <= irq_next;
			edge_cnt_reg <= edge_cnt_next;
			resync_reg <= resync_next;
		end
	end

	//***************************************************************
	// Outputs
	//***************************************************************
	// Source change is a registered level, so the mux sees no glitch
	assign sel_o = sel_reg;
	assign core_from_freerun_o = failed_reg; // R16
	assign multiplier_enable_o = (sel_reg.mode == ccs_pkg::CCS_MODE_MULT); // R05
	// Multiplier off when not multiplying, supervision is off and no failure is latched
	assign multiplier_freerun_o = direct_like && (supv_on || failed_reg); // R15
	assign prescale_enable_o = (sel_reg.mode == ccs_pkg::CCS_MODE_PRESCALE); // R03
	assign resync_pulse_o = resync_reg;
	assign clock_fail_irq_request_o = irq_reg;
endmodule : ccs_clock_select

// *** ccs_clock_select_asserts.sv ***
// Checker bound to the core clock select ports
`timescale 1ns/1ps
module ccs_clock_select_asserts (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [2:0] clock_mode_strap_pins_i,
	input wire logic crystal_input_pin_i,
	input wire logic [7:0] system_config_register_i,
	input wire ccs_pkg::ccs_sel_s sel_o,
	input wire logic multiplier_enable_o,
	input wire logic multiplier_freerun_o,
	input wire logic prescale_enable_o,
	input wire logic core_from_freerun_o,
	input wire logic resync_pulse_o,
	input wire logic clock_fail_irq_request_o
);
	wire mult = sel_o.mode == ccs_pkg::CCS_MODE_MULT;
	wire watch_on = !mult && !system_config_register_i[4];
	logic pin_reg;
	logic [5:0] quiet_reg;
	logic [5:0] quiet_next;
	// Quiet cycles since the pin last moved; counts a few edges early since the pin is seen before sync
	always_comb begin
		quiet_next = (crystal_input_pin_i != pin_reg || !watch_on) ? 6'h0 : quiet_reg + {5'h0, quiet_reg != 6'h3f};
	end
	always_ff @(posedge clock_i) begin
		pin_reg <= crystal_input_pin_i;
		quiet_reg <= rst_n_i ? quiet_next : 6'h0;
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	property p_hold; $past(rst_n_i) |-> $stable(sel_o); endproperty
	a_hold: assert property (p_hold) else $error("mode moved");
	property p_men; multiplier_enable_o == mult; endproperty
	a_men: assert property (p_men) else $error("mult enable");
	property p_pre; prescale_enable_o == (sel_o.mode == ccs_pkg::CCS_MODE_PRESCALE); endproperty
	a_pre: assert property (p_pre) else $error("prescale");
	property p_free; multiplier_freerun_o == (!mult && (!system_config_register_i[4] || core_from_freerun_o)); endproperty
	a_free: assert property (p_free) else $error("free run");
	property p_keep; core_from_freerun_o |=> core_from_freerun_o; endproperty
	a_keep: assert property (p_keep) else $error("failover lost");
	property p_irq; clock_fail_irq_request_o == core_from_freerun_o; endproperty
	a_irq: assert property (p_irq) else $error("irq apart");
	property p_late; $rose(core_from_freerun_o) |-> !mult && quiet_reg >= 6'h10; endproperty
	a_late: assert property (p_late) else $error("early fail");
	property p_due; quiet_reg >= 6'h18 |-> core_from_freerun_o; endproperty
	a_due: assert property (p_due) else $error("missed fail");
	property p_rsy; resync_pulse_o |-> mult ##1 !resync_pulse_o; endproperty
	a_rsy: assert property (p_rsy) else $error("resync");
	c_fail: cover property ($rose(core_from_freerun_o));
	c_rsy: cover property (resync_pulse_o);
	c_pre: cover property (prescale_enable_o && quiet_reg > 6'h4);
endmodule : ccs_clock_select_asserts
bind ccs_clock_select ccs_clock_select_asserts u_chk (.*);

// *** ccs_clock_select_tb.sv ***
// Self-checking bench for the core clock select block
`timescale 1ns/1ps
module ccs_clock_select_tb;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [2:0] clock_mode_strap_pins_i = 3'h7;
	logic [7:0] system_config_register_i = 8'h00;
	logic crystal_input_pin_i;
	ccs_pkg::ccs_sel_s sel_o;
	logic multiplier_enable_o, multiplier_freerun_o, prescale_enable_o;
	logic core_from_freerun_o, resync_pulse_o, clock_fail_irq_request_o;
	logic run = 1'b0;
	logic [1:0] half = 2'h1;
	logic ef;
	ccs_pkg::ccs_mode_e md;
	int num_errors = 0;
	int n_checks = 0;
	int hf[8] = '{5, 1, 3, 2, 10, 4, 6, 8};
	int pulses;
	int k;
	always #25 clock_i = ~clock_i;
	ccs_xtal_model xtal (.clock_i(clock_i), .run_i(run), .half_i(half), .pin_o(crystal_input_pin_i));
	ccs_clock_select DUT (.*);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task final_report;
		if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report
	// Every strap code with supervision on, then off; each pass opens with its own reset
	initial begin
		k = $urandom(61509);
		repeat (2) @(posedge clock_i);
		for (int s = 0; s < 16; s++) begin
			rst_n_i <= 1'b0;
			clock_mode_strap_pins_i <= s[2:0];
			system_config_register_i <= {3'($urandom), s[3], 4'($urandom)};
			half <= 2'($urandom_range(3, 1));
			run <= 1'b1;
			md = (s[2:0] == 3'h1) ? ccs_pkg::CCS_MODE_PRESCALE : (s[2:0] == 3'h3) ? ccs_pkg::CCS_MODE_DIRECT : ccs_pkg::CCS_MODE_MULT;
			ef = md != ccs_pkg::CCS_MODE_MULT && !s[3];
			repeat (4) @(posedge clock_i);
			rst_n_i <= 1'b1;
			clock_mode_strap_pins_i <= 3'($urandom);
			pulses = 0;
			repeat (60) begin
				@(posedge clock_i);
				pulses += resync_pulse_o;
			end
			chk(sel_o, {md, 4'(hf[s[2:0]])});
			chk(multiplier_enable_o, md == ccs_pkg::CCS_MODE_MULT);
			chk(prescale_enable_o, md == ccs_pkg::CCS_MODE_PRESCALE);
			chk(pulses > 0, md == ccs_pkg::CCS_MODE_MULT);
			chk(core_from_freerun_o, 1'b0);
			chk(multiplier_freerun_o, ef);
			// Stall the source; the watch limit is 16, so 40 cycles is ample
			run <= 1'b0;
			k = 0;
			while (k < 40 && core_from_freerun_o !== 1'b1) begin
				@(posedge clock_i);
				k++;
			end
			chk(core_from_freerun_o, ef);
			chk(clock_fail_irq_request_o, ef);
			// A failover that never came has been counted above; stop here
			if (ef && k >= 40) final_report();
			run <= 1'b1;
			repeat (20) @(posedge clock_i);
			chk(core_from_freerun_o, ef);
		end
		final_report();
	end
endmodule : ccs_clock_select_tb

// *** ccs_edge_sync.sv ***
// Synchroniser and edge detector for the sampled input clock level
`timescale 1ns/1ps
module ccs_edge_sync (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic level_i,
	output logic edge_o
);
	logic meta_reg, meta_next;
	logic stable_reg, stable_next;
	logic last_reg, last_next;

	// Two-stage sync; the second stage and its delayed copy feed the edge compare
	always_comb begin
		meta_next = level_i;
		stable_next = meta_reg;
		last_next = stable_reg;
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			meta_reg <= 1'b0;
			stable_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= meta_next;
			stable_reg <= stable_next;
			last_reg <= last_next;
		end
	end

	assign edge_o = stable_reg ^ last_reg;
endmodule : ccs_edge_sync

// *** ccs_pkg.sv ***
// Types shared by the core clock select files
package ccs_pkg;
	typedef enum logic [2:0] {
		CCS_MODE_PRESCALE = 3'b001,
		CCS_MODE_DIRECT = 3'b010,
		CCS_MODE_MULT = 3'b100
	} ccs_mode_e;
	typedef enum logic [1:0] {
		CCS_SRC_INPUT = 2'b01,
		CCS_SRC_FREERUN = 2'b10
	} ccs_src_e;
	// Factor held in halves, so 1.5 is 3
	typedef logic [3:0] ccs_half_factor_t;
	typedef struct packed {
		ccs_mode_e mode;
		ccs_half_factor_t half_factor;
	} ccs_sel_s;
endpackage : ccs_pkg

// *** ccs_watch_counter.sv ***
// Counter that measures free-running ticks between input clock edges
`timescale 1ns/1ps
`include "ccs_cfg.svh"
module ccs_watch_counter (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic run_i,
	input wire logic clear_i,
	output logic overflow_o
);
	logic [4:0] count_reg, count_next;

	// Clear wins, counting stops at the limit
	always_comb begin
		count_next = count_reg;
		if (!run_i || clear_i) begin
			count_next = 5'h00; // R10
		end else if (count_reg != `CCS_WATCH_LIMIT) begin
			count_next = count_reg + 5'h01; // R09
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			count_reg <= 5'h00;
		end else begin
			count_reg <= count_next;
		end
	end

	assign overflow_o = (count_reg == `CCS_WATCH_LIMIT); // R11
endmodule : ccs_watch_counter

// *** ccs_xtal_model.sv ***
// Crystal source model on the far side of the input clock pin
`timescale 1ns/1ps
module ccs_xtal_model (
	input wire logic clock_i,
	input wire logic run_i,
	input wire logic [1:0] half_i,
	output logic pin_o
);
	logic [1:0] cnt_reg = 2'h0;
	initial pin_o = 1'b0;
	// A stopped source holds its last level, as a dead crystal does
	always @(posedge clock_i) begin
		cnt_reg <= (cnt_reg >= half_i) ? 2'h0 : cnt_reg + 2'h1;
		if (run_i && cnt_reg >= half_i) pin_o <= ~pin_o;
	end
endmodule : ccs_xtal_model
